// ### rtl/irs_sequencer.sv
`timescale 1ns/100ps
module irs_sequencer #(
  parameter bit HAS_RC_OSC = 1'b0,
  parameter int WDT_PERIOD = irs_pkg::WDT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Reset sources
  input wire logic external_reset_n,
  input wire logic [irs_pkg::KEY_PINS-1:0] key_port_group,
  // Software control
  input wire logic [irs_pkg::KEY_PINS-1:0] key_select,
  input wire logic key_reset_enable,
  input wire logic watchdog_run,
  input wire logic watchdog_restart,
  input wire logic watchdog_reset_select,
  // Vector fetch
  output logic vector_read,
  output logic [15:0] vector_address,
  input wire logic [15:0] vector_data,
  // Core state
  output logic cpu_halt,
  output logic peripheral_reset,
  output logic flash_reset,
  output logic boot_from_rc,
  output logic watchdog_nmi,
  output logic [15:0] program_counter,
  output logic [15:0] stack_pointer,
  output logic [7:0] processor_status_word,
  output logic [15:0] vector_table_base,
  output logic core_reset_clear
);
  import irs_pkg::*;

  // ****************************************
  // Reset source merge
  // ****************************************
  logic key_en;
  logic wdt_en;
  logic wdt_sel;
  logic wdt_overflow;
  logic sync_a;
  logic sync_b;
  irs_state_t state;
  logic [10:0] count;

  wire logic key_hit = key_en && (key_select != '0)
    && ((key_port_group & key_select) == '0);
  wire logic wdt_reset = wdt_en && wdt_sel && wdt_overflow;
  wire logic any_reset = reset || !external_reset_n || key_hit || wdt_reset;

  function automatic logic [10:0] wait_len(input irs_state_t s);
    case (s)
      IRS_OSC_WAIT: wait_len = HAS_RC_OSC ? 11'(RC_WAIT_CYCLES - 1)
                                          : 11'(CRYSTAL_WAIT_CYCLES - 1);
      IRS_CLK_START: wait_len = 11'(CLOCK_START_CYCLES - 1);
      IRS_FLASH_REL: wait_len = 11'(FLASH_RELEASE_CYCLES - 1);
      default: wait_len = 11'h000;
    endcase
  endfunction

  wire logic phase_done = (count == wait_len(state));

  // ****************************************
  // Watchdog
  // ****************************************
  irs_watchdog #(.PERIOD(WDT_PERIOD)) u_wdt (
    .clk(clk),
    .reset(sync_b),
    .wdt_run(watchdog_run && wdt_en),
    .wdt_restart(watchdog_restart),
    .overflow(wdt_overflow)
  );

  // ****************************************
  // Release synchroniser
  // ****************************************
  always_ff @(posedge clk) begin
    if (any_reset) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= 1'b0;
      sync_b <= sync_a;
    end
  end

  // ****************************************
  // Software enables
  // ****************************************
  always_ff @(posedge clk) begin
    if (sync_b) begin
      key_en <= 1'b0;
      wdt_en <= 1'b0;
      wdt_sel <= 1'b0;
    end else begin
      key_en <= key_reset_enable;
      wdt_en <= watchdog_run;
      wdt_sel <= watchdog_reset_select;
    end
  end

  // ****************************************
  // Boot sequence
  // ****************************************
  irs_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      IRS_HELD: next_state = IRS_OSC_WAIT;
      IRS_OSC_WAIT: if (phase_done) next_state = IRS_CLK_START;
      IRS_CLK_START: if (phase_done) next_state = IRS_FLASH_REL;
      IRS_FLASH_REL: if (phase_done) next_state = IRS_VEC_FETCH;
      IRS_VEC_FETCH: next_state = IRS_RUN;
      default: next_state = IRS_RUN;
    endcase
  end

  wire logic [10:0] next_count = (phase_done || state == IRS_HELD) ? 11'h000 : count + 11'h001;

  always_ff @(posedge clk) begin
    if (sync_b) begin
      state <= IRS_HELD;
      count <= 11'h000;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // ****************************************
  // Core output decode
  // ****************************************
  wire logic flash_done = (state == IRS_FLASH_REL) && phase_done;
  wire logic load_pc = (state == IRS_RUN) && cpu_halt;
  wire logic next_flash_reset = flash_reset && !flash_done;
  wire logic next_core_clear = (state == IRS_HELD) || (state == IRS_OSC_WAIT);
  wire logic next_watchdog_nmi = wdt_en && !wdt_sel && wdt_overflow;
  wire logic [15:0] fetch_address = vector_table_base + RESET_VECTOR_OFFSET;

  // ****************************************
  // Halt and program counter
  // ****************************************
  // Vector data stands one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sync_b) begin
      cpu_halt <= 1'b1;
      program_counter <= GPR_RESET;
    end else if (load_pc) begin
      cpu_halt <= 1'b0;
      program_counter <= vector_data;
    end
  end

  // ****************************************
  // Reset strobes
  // ****************************************
  always_ff @(posedge clk) begin
    if (sync_b) begin
      peripheral_reset <= 1'b1;
      flash_reset <= 1'b1;
      core_reset_clear <= 1'b1;
    end else begin
      peripheral_reset <= 1'b0;
      flash_reset <= next_flash_reset;
      core_reset_clear <= next_core_clear;
    end
  end

  // ****************************************
  // Vector fetch
  // ****************************************
  always_ff @(posedge clk) begin
    if (sync_b) begin
      vector_read <= 1'b0;
      vector_address <= VECTOR_BASE_RESET + RESET_VECTOR_OFFSET;
      vector_table_base <= VECTOR_BASE_RESET;
    end else begin
      vector_read <= flash_done;
      vector_address <= fetch_address;
    end
  end

  // ****************************************
  // Core registers and interrupt
  // ****************************************
  always_ff @(posedge clk) begin
    if (sync_b) begin
      stack_pointer <= SP_RESET;
      processor_status_word <= PSW_RESET;
      watchdog_nmi <= 1'b0;
    end else begin
      watchdog_nmi <= next_watchdog_nmi;
    end
  end

  // ****************************************
  // Boot clock select
  // ****************************************
  always_ff @(posedge clk) begin
    boot_from_rc <= HAS_RC_OSC;
  end
endmodule

// ### rtl/irs_pkg.sv
package irs_pkg;
  // ****************************************
  // Sequence timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int CRYSTAL_WAIT_CYCLES = 1024;
  localparam int RC_WAIT_CYCLES = 64;
  localparam int CLOCK_START_CYCLES = 8;
  localparam int FLASH_RELEASE_CYCLES = 16;
  localparam int WDT_PERIOD_S = 4;
  localparam int WDT_CYCLES = WDT_PERIOD_S * CLK_HZ;
  localparam int CNT_W = 27;
  // ****************************************
  // Core reset values
  // ****************************************
  localparam logic [15:0] VECTOR_BASE_RESET = 16'h8000;
  localparam logic [15:0] RESET_VECTOR_OFFSET = 16'h0000;
  localparam logic [15:0] GPR_RESET = 16'h0000;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam int KEY_PINS = 4;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    IRS_HELD = 3'b000,
    IRS_OSC_WAIT = 3'b001,
    IRS_CLK_START = 3'b010,
    IRS_FLASH_REL = 3'b011,
    IRS_VEC_FETCH = 3'b100,
    IRS_RUN = 3'b101
  } irs_state_t;
endpackage

// ### rtl/irs_watchdog.sv
`timescale 1ns/100ps
module irs_watchdog #(
  parameter int PERIOD = irs_pkg::WDT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic wdt_run,
  input wire logic wdt_restart,
  // Overflow
  output logic overflow
);
  import irs_pkg::*;
  logic [CNT_W-1:0] count;
  wire logic at_end = (count == CNT_W'(PERIOD - 1));
  wire logic [CNT_W-1:0] next_count = (!wdt_run || wdt_restart || at_end) ? '0 : count + 1'b1;
  // ****************************************
  // Four-second overflow counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      overflow <= 1'b0;
    end else begin
      count <= next_count;
      overflow <= wdt_run && !wdt_restart && at_end;
    end
  end
endmodule

// ### dv/irs_vector_memory.sv
`timescale 1ns/100ps
// ****************
// Vector memory
// ****************
module irs_vector_memory #(
  parameter logic [15:0] VECTOR = 16'h1234
) (
  // Clock
  input wire logic clk,
  // Read port
  input wire logic vector_read,
  input wire logic [15:0] vector_address,
  output logic [15:0] vector_data
);
  initial vector_data = 16'h0;
  // Valid only the cycle after a read
  always @(posedge clk) begin
    if (vector_read) begin
      vector_data <= (vector_address == 16'h8000) ? VECTOR : 16'hdead;
    end else begin
      vector_data <= ~vector_data;
    end
  end
endmodule

// ### dv/irs_sequencer_properties.sv
`timescale 1ns/100ps
module irs_sequencer_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sources
  input wire logic external_reset_n,
  input wire logic [3:0] key_port_group,
  input wire logic [3:0] key_select,
  input wire logic key_reset_enable,
  input wire logic watchdog_reset_select,
  // Core side
  input wire logic vector_read,
  input wire logic [15:0] vector_address,
  input wire logic [15:0] vector_data,
  input wire logic cpu_halt,
  input wire logic flash_reset,
  input wire logic watchdog_nmi,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] stack_pointer,
  input wire logic [7:0] processor_status_word,
  input wire logic [15:0] vector_table_base
);
  logic [11:0] quiet;
  wire key_hit = key_reset_enable && |key_select && (key_port_group & key_select) == 4'h0;
  wire src = !external_reset_n || key_hit;
  // Cycles since a source was last active
  always_ff @(posedge clk) begin
    if (reset || src) quiet <= 12'h0;
    else if (quiet != 12'hfff) quiet <= quiet + 12'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  src_halt_a: assert property (src |-> ##[1:3] cpu_halt) else $error("no halt");
  wait_len_a: assert property (vector_read |-> quiet >= 12'h419) else $error("early");
  flash_order_a: assert property ($fell(flash_reset) |-> ##[0:2] vector_read) else $error("order");
  vec_addr_a: assert property (vector_read |-> vector_address == 16'h8000) else $error("addr");
  pc_load_a: assert property (vector_read ##1 1'b1 |=>
    program_counter == $past(vector_data) && !cpu_halt) else $error("pc");
  core_clear_a: assert property (cpu_halt |->
    stack_pointer == 16'h0 && processor_status_word == 8'h0) else $error("clear");
  table_base_a: assert property (vector_table_base == 16'h8000) else $error("base");
  nmi_select_a: assert property (watchdog_nmi |-> !$past(watchdog_reset_select, 2)) else $error("nmi");
  cover property (vector_read);
  cover property (watchdog_nmi);
  cover property (key_hit);
endmodule
bind irs_sequencer irs_sequencer_properties irs_sequencer_properties_i (
  .clk(clk),
  .reset(reset),
  .external_reset_n(external_reset_n),
  .key_port_group(key_port_group),
  .key_select(key_select),
  .key_reset_enable(key_reset_enable),
  .watchdog_reset_select(watchdog_reset_select),
  .vector_read(vector_read),
  .vector_address(vector_address),
  .vector_data(vector_data),
  .cpu_halt(cpu_halt),
  .flash_reset(flash_reset),
  .watchdog_nmi(watchdog_nmi),
  .program_counter(program_counter),
  .stack_pointer(stack_pointer),
  .processor_status_word(processor_status_word),
  .vector_table_base(vector_table_base)
);

// ### dv/test_initial_reset_sequencer.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module test_initial_reset_sequencer;
  import irs_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic external_reset_n, key_reset_enable, watchdog_run, watchdog_restart, watchdog_reset_select;
  logic [3:0] key_port_group, key_select;
  logic vector_read, cpu_halt, peripheral_reset, flash_reset, boot_from_rc, watchdog_nmi;
  logic core_reset_clear;
  logic [15:0] vector_address, vector_data, program_counter, stack_pointer, vector_table_base;
  logic [7:0] processor_status_word;
  int n_fail = 0;
  int check_count = 0;
  int n;
  // Rows: key select, key pins, enable, halt expected
  logic [9:0] rows [5] = '{10'h3c0, 10'h002, 10'h0f3, 10'h0c6, 10'h3c3};
  irs_sequencer #(.WDT_PERIOD(100)) irs_sequencer_i (
    .clk(clk),
    .reset(reset),
    .external_reset_n(external_reset_n),
    .key_port_group(key_port_group),
    .key_select(key_select),
    .key_reset_enable(key_reset_enable),
    .watchdog_run(watchdog_run),
    .watchdog_restart(watchdog_restart),
    .watchdog_reset_select(watchdog_reset_select),
    .vector_read(vector_read),
    .vector_address(vector_address),
    .vector_data(vector_data),
    .cpu_halt(cpu_halt),
    .peripheral_reset(peripheral_reset),
    .flash_reset(flash_reset),
    .boot_from_rc(boot_from_rc),
    .watchdog_nmi(watchdog_nmi),
    .program_counter(program_counter),
    .stack_pointer(stack_pointer),
    .processor_status_word(processor_status_word),
    .vector_table_base(vector_table_base),
    .core_reset_clear(core_reset_clear)
  );
  irs_vector_memory irs_vector_memory_i (
    .clk(clk),
    .vector_read(vector_read),
    .vector_address(vector_address),
    .vector_data(vector_data)
  );
  initial forever #25 clk = ~clk;
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic boot(input bit timed);
    n = 0;
    while (cpu_halt !== 1'b0 && n < 3000) begin
      step(1);
      n++;
    end
    if (timed) `CHK("boot_len", 1'b1, n >= 1049 && n <= 1065)
    `CHK("pc", 16'h1234, program_counter)
  endtask
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #1500000;
    n_fail++;
    end_sim();
  end
  initial begin
    {external_reset_n, key_port_group, key_select} = 9'h1f0;
    {key_reset_enable, watchdog_run, watchdog_restart, watchdog_reset_select} = 4'h0;
    step(2);
    reset <= 1'b0;
    boot(1);
    `CHK("base", 16'h8000, vector_table_base)
    `CHK("boot_rc", 1'b0, boot_from_rc)
    `CHK("run_lines", 3'h0, {peripheral_reset, core_reset_clear, flash_reset})
    for (int i = 0; i < 5; i++) begin
      {key_select, key_port_group, key_reset_enable} <= rows[i][9:1];
      step(4);
      `CHK("key_halt", rows[i][0], cpu_halt)
      key_port_group <= 4'hf;
      key_reset_enable <= 1'b0;
      if (rows[i][0]) boot(1);
      else step(1);
    end
    external_reset_n <= 1'b0;
    step(3);
    `CHK("pin_halt", 1'b1, cpu_halt)
    `CHK("hold_lines", 3'h7, {peripheral_reset, core_reset_clear, flash_reset})
    external_reset_n <= 1'b1;
    step(600);
    external_reset_n <= 1'b0;
    step(1);
    external_reset_n <= 1'b1;
    boot(1);
    {watchdog_run, watchdog_reset_select} <= 2'h3;
    repeat (6) begin
      step(60);
      watchdog_restart <= 1'b1;
      step(1);
      watchdog_restart <= 1'b0;
    end
    `CHK("wdt_kept", 1'b0, cpu_halt)
    watchdog_reset_select <= 1'b0;
    for (n = 0; watchdog_nmi !== 1'b1 && n < 200; n++) step(1);
    `CHK("nmi", 2'h2, {watchdog_nmi, cpu_halt})
    watchdog_reset_select <= 1'b1;
    for (n = 0; cpu_halt !== 1'b1 && n < 200; n++) step(1);
    `CHK("wdt_halt", 1'b1, cpu_halt)
    watchdog_run <= 1'b0;
    boot(0);
    end_sim();
  end
endmodule
